/* core/bus_bit_engine.sv */
// bit level engine of the 2-wire serial slave: start/stop, byte shift, ack, read shift
// assumes scl and sda arrive asynchronously and scl half periods span many clocks
`default_nettype none

module bus_bit_engine (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_in,
	input wire logic ack,
	input wire logic tx_load,
	input wire logic [7:0] tx_byte,
	output csr_pkg::bus_event_s ev,
	output logic sda_oe_n
);

	logic [2:0] scl_sync_q;
	logic [2:0] sda_sync_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic txing_q;

	// stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
	wire scl_s = scl_sync_q[1];
	wire sda_s = sda_sync_q[1];
	wire scl_rise = scl_s & ~scl_sync_q[2];
	wire scl_fall = ~scl_s & scl_sync_q[2];
	wire start_w = scl_s & scl_sync_q[2] & sda_sync_q[2] & ~sda_s;
	wire stop_w = scl_s & scl_sync_q[2] & ~sda_sync_q[2] & sda_s;
	wire [7:0] shifted = {shift_q[6:0], sda_s};

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
			bit_cnt_q <= csr_pkg::BIT_CNT_ZERO;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			txing_q <= 1'b0;
			sda_oe_n <= 1'b1;
			ev <= '0;
		end else begin
			scl_sync_q <= {scl_sync_q[1:0], scl};
			sda_sync_q <= {sda_sync_q[1:0], sda_in};
			ev.start <= start_w;
			ev.stop <= stop_w;
			ev.byte_valid <= 1'b0;
			if (start_w || stop_w) begin
				bit_cnt_q <= csr_pkg::BIT_CNT_ZERO;
				txing_q <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				if (bit_cnt_q == csr_pkg::BIT_CNT_ACK) begin
					bit_cnt_q <= csr_pkg::BIT_CNT_ZERO;
				end else begin
					bit_cnt_q <= bit_cnt_q + 4'h1;
					shift_q <= shifted;
				end
				if (bit_cnt_q == csr_pkg::BIT_CNT_DATA_LAST && !txing_q) begin
					ev.byte_valid <= 1'b1;
					ev.data <= shifted;
				end
			end else if (scl_fall) begin
				// the master answers its own read byte, so only written bytes get our ack
				if (bit_cnt_q == csr_pkg::BIT_CNT_ACK) begin
					sda_oe_n <= txing_q | ~ack;
				end else if (bit_cnt_q == csr_pkg::BIT_CNT_ZERO) begin
					if (tx_load && !txing_q) begin
						txing_q <= 1'b1;
						tx_q <= {tx_byte[6:0], 1'b0};
						sda_oe_n <= tx_byte[7];
					end else begin
						sda_oe_n <= 1'b1;
					end
				end else if (txing_q) begin
					sda_oe_n <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end

endmodule : bus_bit_engine

`default_nettype wire

/* core/control_status_write_guard.sv */
// control and status register with its write guard, reached over the 2-wire serial bus
// assumes reset_n marks a power cycle; monitor outputs and pins are asynchronous inputs
//
// Behaviour
// - power-up clears volatile bits; nonvolatile bits keep their stored value
// - with the write-enable latch clear, writes other than 00000010 abort and the data byte gets no ack
// - 00000010 sets the write-enable latch; 00000000 or power cycle clears it
// - latch-only writes start no programming cycle; ready right after stop
// - bits other than the write-enable latch and unlock are written only when unlock is set
// - unlock can be set only while the write-enable latch is already set
// - unlock clears after a completed register write and on power-down
// - write lock set rejects all pot wiper writes; factory value is 0
// - write-protect pin high blocks nonvolatile pot writes regardless of lock
// - reset-delay select 00/01/10/11 gives 50/100/200/300 ms, default 100
// - supply reset stays high until supply good for the selected hold time
// - reset-delay select bits are nonvolatile and restore after power-up
// - monitor flags power up 0; a write sets one only while its monitor is high
// - a set monitor flag clears when its monitor output goes low or power cycles
// - register reached with slave address 1010010 and address byte ffh
// - one data byte per write; a further byte gets no ack and aborts the write
// - stop after the data byte starts the nonvolatile store, about 5 ms
// - final write with bit 2 set only sets unlock and loads the write-enable latch from bit 1, other bits unchanged
// - layout: 7 delay hi, 6/5 monitor flags, 4 reserved, 3 lock, 2 unlock, 1 wel, 0 delay lo
// - nonvolatile bits ignore writes while the write-protect pin is high
// - reserved bit 4 always reads 0
`default_nettype none

module control_status_write_guard #(
	parameter int CLOCKS_PER_MS = csr_pkg::CLOCKS_PER_MS,
	parameter int NV_STORE_CYCLES = csr_pkg::NV_STORE_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic write_protect,
	input wire logic supply_ok,
	input wire logic manual_reset,
	input wire logic mon2_reset_out,
	input wire logic mon3_reset_out,
	output logic supply_reset_out,
	output logic pot_volatile_write_ok,
	output logic pot_nv_write_ok,
	output logic nv_store_busy,
	output logic [7:0] control_status_register
);

	localparam int BUSY_W = $clog2(NV_STORE_CYCLES + 1);

	if (NV_STORE_CYCLES < 1) begin : g_bad_store
		$error("control_status_write_guard: NV_STORE_CYCLES must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage 1 is read only by stage 2
	// clearing to 0 makes the supply look bad, so every power cycle restarts the hold time

	logic [3:0] pin_sync1_q;
	logic [3:0] pin_sync2_q;

	wire wp_s = pin_sync2_q[0];
	wire supply_ok_s = pin_sync2_q[1];
	wire mon2_s = pin_sync2_q[2];
	wire mon3_s = pin_sync2_q[3];
	logic mr_sync1_q;
	logic mr_sync2_q;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pin_sync1_q <= 4'h0;
			pin_sync2_q <= 4'h0;
			mr_sync1_q <= 1'b0;
			mr_sync2_q <= 1'b0;
		end else begin
			pin_sync1_q <= {mon3_reset_out, mon2_reset_out, supply_ok, write_protect};
			pin_sync2_q <= pin_sync1_q;
			mr_sync1_q <= manual_reset;
			mr_sync2_q <= mr_sync1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register state

	logic wel_q;
	logic wel_d;
	logic unlock_q;
	logic unlock_d;
	logic mon2_flag_q;
	logic mon2_flag_d;
	logic mon3_flag_q;
	logic mon3_flag_d;
	// nonvolatile cells: no reset, the initial value stands for the factory contents
	logic [1:0] sel_nv_q = csr_pkg::SEL_DEFAULT;
	logic lock_nv_q = csr_pkg::LOCK_DEFAULT;
	logic [BUSY_W-1:0] busy_cnt_q;

	wire busy = busy_cnt_q != '0;
	wire [7:0] status_byte = {sel_nv_q[1], mon2_flag_q, mon3_flag_q, 1'b0,
		lock_nv_q, unlock_q, wel_q, sel_nv_q[0]};

	////////////////////////////////////////////////////////////////////////////////
	// serial transaction tracking

	csr_pkg::bus_event_s ev;
	csr_pkg::xfer_state_e state_q;
	csr_pkg::xfer_state_e state_d;
	logic ack_q;
	logic ack_d;
	logic tx_load_q;
	logic tx_load_d;
	logic [7:0] pend_q;
	logic [7:0] pend_d;
	logic pend_valid_q;
	logic pend_valid_d;

	wire addr_hit = ev.data[7:1] == csr_pkg::SLAVE_ADDR;
	wire is_read = ev.data[0];
	wire word_hit = ev.data == csr_pkg::REG_ADDR;
	// with the latch clear only the latch-set byte is taken; anything else goes unacked
	wire data_ok = wel_q | (ev.data == csr_pkg::WEL_SET_BYTE);
	wire commit = ev.stop & pend_valid_q;
	wire full_write = commit & unlock_q & ~pend_q[csr_pkg::BIT_UNLOCK];
	wire nv_write = full_write & ~wp_s;

	always_comb begin
		state_d = state_q;
		ack_d = ack_q;
		tx_load_d = tx_load_q;
		pend_d = pend_q;
		pend_valid_d = pend_valid_q;
		if (ev.start) begin
			// a write left without its stop never takes effect
			state_d = csr_pkg::ST_ADDR;
			ack_d = 1'b0;
			tx_load_d = 1'b0;
			pend_valid_d = 1'b0;
		end else if (ev.stop) begin
			state_d = csr_pkg::ST_IDLE;
			ack_d = 1'b0;
			tx_load_d = 1'b0;
			pend_valid_d = 1'b0;
		end else if (ev.byte_valid) begin
			case (state_q)
				csr_pkg::ST_ADDR: begin
					// writes wait out a store; reads may run alongside it
					ack_d = addr_hit & (is_read | ~busy);
					if (!ack_d) begin
						state_d = csr_pkg::ST_IGNORE;
					end else if (is_read) begin
						state_d = csr_pkg::ST_READ;
						tx_load_d = 1'b1;
					end else begin
						state_d = csr_pkg::ST_WORD;
					end
				end
				csr_pkg::ST_WORD: begin
					ack_d = word_hit;
					state_d = word_hit ? csr_pkg::ST_DATA : csr_pkg::ST_IGNORE;
				end
				csr_pkg::ST_DATA: begin
					ack_d = data_ok;
					pend_d = ev.data;
					pend_valid_d = data_ok;
					state_d = csr_pkg::ST_EXTRA;
				end
				csr_pkg::ST_EXTRA: begin
					ack_d = 1'b0;
					pend_valid_d = 1'b0;
					state_d = csr_pkg::ST_IGNORE;
				end
				default: begin
					ack_d = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register update on a committed write

	always_comb begin
		wel_d = wel_q;
		unlock_d = unlock_q;
		// the flags follow the monitor level, so a 1 written while a monitor is low is lost
		mon2_flag_d = mon2_flag_q & mon2_s;
		mon3_flag_d = mon3_flag_q & mon3_s;
		if (commit) begin
			wel_d = pend_q[csr_pkg::BIT_WEL];
			if (!unlock_q) begin
				unlock_d = pend_q[csr_pkg::BIT_UNLOCK] & wel_q;
			end else if (pend_q[csr_pkg::BIT_UNLOCK]) begin
				unlock_d = 1'b1;
			end else begin
				unlock_d = 1'b0;
				mon2_flag_d = pend_q[csr_pkg::BIT_MON2] & mon2_s;
				mon3_flag_d = pend_q[csr_pkg::BIT_MON3] & mon3_s;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wel_q <= 1'b0;
			unlock_q <= 1'b0;
			mon2_flag_q <= 1'b0;
			mon3_flag_q <= 1'b0;
		end else begin
			wel_q <= wel_d;
			unlock_q <= unlock_d;
			mon2_flag_q <= mon2_flag_d;
			mon3_flag_q <= mon3_flag_d;
		end
	end

	// cells survive reset_n, so the stored selection comes back after power-up
	always_ff @(posedge clock) begin
		if (nv_write) begin
			sel_nv_q <= {pend_q[csr_pkg::BIT_SEL_HI], pend_q[csr_pkg::BIT_SEL_LO]};
			lock_nv_q <= pend_q[csr_pkg::BIT_LOCK];
		end
	end

	// only a full register write programs; latch and unlock writes leave busy low
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busy_cnt_q <= '0;
		end else if (nv_write) begin
			busy_cnt_q <= BUSY_W'(NV_STORE_CYCLES);
		end else if (busy) begin
			busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_q <= csr_pkg::ST_IDLE;
			ack_q <= 1'b0;
			tx_load_q <= 1'b0;
			pend_q <= 8'h00;
			pend_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ack_q <= ack_d;
			tx_load_q <= tx_load_d;
			pend_q <= pend_d;
			pend_valid_q <= pend_valid_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sda_out <= 1'b0;
			pot_volatile_write_ok <= 1'b0;
			pot_nv_write_ok <= 1'b0;
			nv_store_busy <= 1'b0;
			control_status_register <= 8'h00;
		end else begin
			sda_out <= 1'b0;
			pot_volatile_write_ok <= wel_q & ~lock_nv_q;
			pot_nv_write_ok <= wel_q & ~lock_nv_q & ~wp_s;
			nv_store_busy <= busy;
			control_status_register <= status_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	bus_bit_engine u_bus (
		.clock(clock),
		.reset_n(reset_n),
		.scl(scl),
		.sda_in(sda_in),
		.ack(ack_q),
		.tx_load(tx_load_q),
		.tx_byte(status_byte),
		.ev(ev),
		.sda_oe_n(sda_oe_n)
	);

	reset_hold_timer #(
		.CLOCKS_PER_MS(CLOCKS_PER_MS)
	) u_hold (
		.clock(clock),
		.reset_n(reset_n),
		.supply_ok(supply_ok_s),
		.manual_reset(mr_sync2_q),
		.delay_sel(sel_nv_q),
		.supply_reset_out(supply_reset_out)
	);

endmodule : control_status_write_guard

`default_nettype wire

/* core/csr_pkg.sv */
// constants, types and helpers shared by the control/status register block
// assumes a single 100 MHz clock and a synchronous active-low reset
`default_nettype none

package csr_pkg;

	localparam int CLOCK_HZ = 100_000_000;
	localparam int CLOCKS_PER_MS = CLOCK_HZ / 1000;

	// serial addressing
	localparam logic [6:0] SLAVE_ADDR = 7'h52;
	localparam logic [7:0] REG_ADDR = 8'hff;
	localparam logic [7:0] WEL_SET_BYTE = 8'h02;

	// register field positions
	localparam int BIT_SEL_HI = 7;
	localparam int BIT_MON2 = 6;
	localparam int BIT_MON3 = 5;
	localparam int BIT_RSVD = 4;
	localparam int BIT_LOCK = 3;
	localparam int BIT_UNLOCK = 2;
	localparam int BIT_WEL = 1;
	localparam int BIT_SEL_LO = 0;

	// factory contents of the nonvolatile bits
	localparam logic [1:0] SEL_DEFAULT = 2'h1;
	localparam logic LOCK_DEFAULT = 1'b0;

	// reset hold times and store time, in milliseconds
	localparam int HOLD_MS_SEL0 = 50;
	localparam int HOLD_MS_SEL1 = 100;
	localparam int HOLD_MS_SEL2 = 200;
	localparam int HOLD_MS_SEL3 = 300;
	localparam int STORE_TIME_MS = 5;
	localparam int NV_STORE_CYCLES = STORE_TIME_MS * CLOCKS_PER_MS;
	localparam int MS_W = 9;

	// bit counter within one serial byte
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
	localparam logic [3:0] BIT_CNT_DATA_LAST = 4'h7;
	localparam logic [3:0] BIT_CNT_ACK = 4'h8;

	typedef struct packed {
		logic start;
		logic stop;
		logic byte_valid;
		logic [7:0] data;
	} bus_event_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WORD,
		ST_DATA,
		ST_EXTRA,
		ST_READ,
		ST_IGNORE
	} xfer_state_e;

	function automatic logic [MS_W-1:0] hold_ms(input logic [1:0] sel);
		case (sel)
			2'h0: hold_ms = MS_W'(HOLD_MS_SEL0);
			2'h1: hold_ms = MS_W'(HOLD_MS_SEL1);
			2'h2: hold_ms = MS_W'(HOLD_MS_SEL2);
			default: hold_ms = MS_W'(HOLD_MS_SEL3);
		endcase
	endfunction : hold_ms

endpackage : csr_pkg

`default_nettype wire

/* core/reset_hold_timer.sv */
// supply reset output timer: holds the reset high for the selected time after supply is good
// assumes supply_ok and manual_reset are already synchronised to clock
`default_nettype none

module reset_hold_timer #(
	parameter int CLOCKS_PER_MS = csr_pkg::CLOCKS_PER_MS
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic supply_ok,
	input wire logic manual_reset,
	input wire logic [1:0] delay_sel,
	output logic supply_reset_out
);

	localparam int DIV_W = $clog2(CLOCKS_PER_MS);

	if (CLOCKS_PER_MS < 2) begin : g_bad_div
		$error("reset_hold_timer: CLOCKS_PER_MS must be at least 2");
	end

	logic [DIV_W-1:0] div_q;
	logic [csr_pkg::MS_W-1:0] ms_q;

	wire ms_tick = div_q == DIV_W'(CLOCKS_PER_MS - 1);
	wire hold_done = ms_q >= csr_pkg::hold_ms(delay_sel);

	////////////////////////////////////////////////////////////////////////////////

	// a low supply or manual reset restarts the whole hold time
	always_ff @(posedge clock) begin
		if (!reset_n || !supply_ok || manual_reset) begin
			div_q <= '0;
			ms_q <= '0;
			supply_reset_out <= 1'b1;
		end else begin
			div_q <= ms_tick ? '0 : div_q + DIV_W'(1);
			if (!hold_done && ms_tick) begin
				ms_q <= ms_q + csr_pkg::MS_W'(1);
			end
			supply_reset_out <= ~hold_done;
		end
	end

endmodule : reset_hold_timer

`default_nettype wire

/* tb/bus_master_model.sv */
// 2-wire serial bus master that talks to the register block
// assumes the bench resolves the open-drain data line with a pull-up
`default_nettype none

module bus_master_model (
	input wire logic clock,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic half();
		repeat (8) @(posedge clock);
	endtask : half
	// data moves two clocks after scl falls, keeping clear of the device hold
	task automatic bit_cycle(input logic low, output logic seen);
		sda_low <= low;
		half();
		scl <= 1'b1;
		half();
		seen = sda_line;
		scl <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : bit_cycle
	task automatic start_cond();
		sda_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b1;
		half();
		scl <= 1'b0;
		half();
	endtask : start_cond
	task automatic stop_cond();
		sda_low <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b0;
		half();
	endtask : stop_cond
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(!d[i], q[i]);
		end
		bit_cycle(1'b0, s);
		ack = !s;
	endtask : xfer
	// an extra data byte is sent only to provoke a refusal
	task automatic wr(input logic [7:0] d, input logic extra, output logic [3:0] ak);
		logic [7:0] q;
		start_cond();
		xfer({csr_pkg::SLAVE_ADDR, 1'b0}, q, ak[0]);
		xfer(csr_pkg::REG_ADDR, q, ak[1]);
		xfer(d, q, ak[2]);
		ak[3] = 1'b0;
		if (extra) begin
			xfer(d, q, ak[3]);
		end
		stop_cond();
	endtask : wr
	task automatic rd(output logic [7:0] q);
		logic [3:0] ak;
		start_cond();
		xfer({csr_pkg::SLAVE_ADDR, 1'b0}, q, ak[0]);
		xfer(csr_pkg::REG_ADDR, q, ak[1]);
		start_cond();
		xfer({csr_pkg::SLAVE_ADDR, 1'b1}, q, ak[2]);
		xfer(8'hff, q, ak[3]);
		stop_cond();
	endtask : rd
endmodule : bus_master_model

`default_nettype wire

/* tb/control_status_write_guard_test.sv */
// self-checking bench of the control/status register block
// assumes the master model and the checker bind are compiled first
`default_nettype none

module control_status_write_guard_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CPM = 10;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic write_protect = 1'b0;
	logic supply_ok = 1'b1;
	logic manual_reset = 1'b0;
	logic mon2_reset_out = 1'b1;
	logic mon3_reset_out = 1'b0;
	logic scl;
	logic sda_low;
	logic sda_oe_n;
	logic sda_out;
	logic supply_reset_out;
	logic vol_ok;
	logic nv_ok;
	logic busy;
	logic [7:0] csr;
	logic [3:0] ak;
	logic [7:0] rq;
	wire logic sda_line;
	int err_total = 0;
	int n_tests = 0;
	assign sda_line = !sda_low && (sda_oe_n || sda_out);
	always #5 clock = !clock;
	bus_master_model master (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
	control_status_write_guard #(.CLOCKS_PER_MS(CPM), .NV_STORE_CYCLES(400)) dut (
		.clock(clock),
		.reset_n(reset_n),
		.scl(scl),
		.sda_in(sda_line),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.write_protect(write_protect),
		.supply_ok(supply_ok),
		.manual_reset(manual_reset),
		.mon2_reset_out(mon2_reset_out),
		.mon3_reset_out(mon3_reset_out),
		.supply_reset_out(supply_reset_out),
		.pot_volatile_write_ok(vol_ok),
		.pot_nv_write_ok(nv_ok),
		.nv_store_busy(busy),
		.control_status_register(csr)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic wait_idle();
		for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
			@(posedge clock);
		end
		check("busy_done", {7'h0, busy}, 8'h00);
	endtask : wait_idle
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_enable_latch();
		check("csr_reset", csr, 8'h01);
		master.wr(8'h06, 1'b0, ak);
		check("ack_no_wel", {4'h0, ak}, 8'h03);
		check("csr_no_wel", csr, 8'h01);
		master.wr(8'h02, 1'b0, ak);
		check("busy_wel", {7'h0, busy}, 8'h00);
		check("csr_wel", csr, 8'h03);
		master.wr(8'h00, 1'b0, ak);
		check("ack_clear", {4'h0, ak}, 8'h07);
		check("csr_clear", csr, 8'h01);
		master.wr(8'h02, 1'b0, ak);
		master.wr(8'h8a, 1'b0, ak);
		check("csr_locked", csr, 8'h03);
	endtask : t_enable_latch
	task automatic t_full_write();
		mon3_reset_out <= 1'b1;
		master.wr(8'h06, 1'b0, ak);
		check("csr_unlock", csr, 8'h07);
		master.wr(8'hea, 1'b0, ak);
		check("busy_store", {7'h0, busy}, 8'h01);
		check("csr_store", csr, 8'hea);
		check("vol_ok_lock", {7'h0, vol_ok}, 8'h00);
		master.wr(8'h00, 1'b0, ak);
		check("ack_busy", {4'h0, ak}, 8'h00);
		wait_idle();
		mon2_reset_out <= 1'b0;
		tick(8);
		check("flag_clear", csr, 8'haa);
	endtask : t_full_write
	task automatic t_guarded_writes();
		mon2_reset_out <= 1'b1;
		master.wr(8'h06, 1'b0, ak);
		master.wr(8'h67, 1'b0, ak);
		check("csr_bit2", csr, 8'hae);
		master.wr(8'h02, 1'b1, ak);
		check("ack_extra", {4'h0, ak}, 8'h07);
		check("csr_extra", csr, 8'hae);
		write_protect <= 1'b1;
		master.wr(8'h02, 1'b0, ak);
		check("busy_wp", {7'h0, busy}, 8'h00);
		check("csr_wp", csr, 8'h8a);
		write_protect <= 1'b0;
		master.wr(8'h06, 1'b0, ak);
		master.wr(8'h02, 1'b0, ak);
		wait_idle();
		check("csr_zero", csr, 8'h02);
		check("ok_open", {6'h0, vol_ok, nv_ok}, 8'h03);
		write_protect <= 1'b1;
		tick(6);
		check("ok_wp", {6'h0, vol_ok, nv_ok}, 8'h02);
		write_protect <= 1'b0;
		master.rd(rq);
		check("read_back", rq, 8'h02);
	endtask : t_guarded_writes
	task automatic t_hold_times();
		int hold_ms[4] = '{50, 100, 200, 300};
		logic [7:0] v;
		int cnt;
		for (int s = 0; s < 4; s++) begin
			v = {s[1], 5'h00, 1'b1, s[0]};
			master.wr(8'h06, 1'b0, ak);
			master.wr(v, 1'b0, ak);
			wait_idle();
			check("csr_sel", csr, v);
			supply_ok <= s[0];
			manual_reset <= s[0];
			tick(10);
			supply_ok <= 1'b1;
			manual_reset <= 1'b0;
			cnt = 0;
			while (supply_reset_out !== 1'b0 && cnt < 4000) begin
				@(posedge clock);
				cnt++;
			end
			check("hold", 8'(cnt >= hold_ms[s] * CPM && cnt <= hold_ms[s] * CPM + 8), 8'h01);
		end
		reset_n <= 1'b0;
		tick(20);
		reset_n <= 1'b1;
		tick(3);
		check("csr_kept", csr, 8'h81);
	endtask : t_hold_times
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(20);
		reset_n <= 1'b1;
		tick(4);
		t_enable_latch();
		t_full_write();
		t_guarded_writes();
		t_hold_times();
		results();
	end
	// the whole run needs about 21000 cycles
	initial begin
		repeat (80000) @(posedge clock);
		err_total++;
		results();
	end
endmodule : control_status_write_guard_test

`default_nettype wire

/* tb/csr_chk.sv */
// port-level checks of the control/status register block
// assumes one clock and the synchronous active-low reset of the block
`default_nettype none

module csr_chk #(
	parameter int NV_STORE_CYCLES = 20
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic write_protect,
	input wire logic supply_ok,
	input wire logic mon2_reset_out,
	input wire logic supply_reset_out,
	input wire logic pot_volatile_write_ok,
	input wire logic pot_nv_write_ok,
	input wire logic nv_store_busy,
	input wire logic [7:0] control_status_register
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] busy_cnt_q;
	default clocking dcb @(posedge clock); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clock) begin
		if (!reset_n || !nv_store_busy) begin
			busy_cnt_q <= 32'h0;
		end else begin
			busy_cnt_q <= busy_cnt_q + 32'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence s_release;
		!reset_n ##1 reset_n;
	endsequence
	// the mirror lags one edge and $stable looks one further back, so reset must have been off for both
	sequence s_wp_held;
		write_protect [*8] ##0 ($past(reset_n) && $past(reset_n, 2));
	endsequence
	property p_release_clear;
		disable iff (1'b0) s_release |-> supply_reset_out ##1
			({control_status_register[6:5], control_status_register[2:1]} == 4'h0);
	endproperty
	property p_rsvd_zero;
		control_status_register[4] == 1'b0;
	endproperty
	property p_supply_low;
		!supply_ok [*5] |-> supply_reset_out;
	endproperty
	property p_mon2_clear;
		!mon2_reset_out [*6] |-> !control_status_register[6];
	endproperty
	property p_vol_ok;
		pot_volatile_write_ok == (control_status_register[1] && !control_status_register[3]);
	endproperty
	property p_wp_nv;
		write_protect [*5] |-> !pot_nv_write_ok;
	endproperty
	property p_wp_keeps;
		s_wp_held |-> $stable({control_status_register[7], control_status_register[3],
			control_status_register[0]});
	endproperty
	property p_busy_unlock;
		$rose(nv_store_busy) |-> !control_status_register[2] ##1 nv_store_busy [*8];
	endproperty
	property p_busy_len;
		busy_cnt_q <= 32'(NV_STORE_CYCLES + 1);
	endproperty
	a_release_clear: assert property (p_release_clear) else $error("volatile bits after reset");
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
	a_supply_low: assert property (p_supply_low) else $error("supply reset low");
	a_mon2_clear: assert property (p_mon2_clear) else $error("monitor flag kept");
	a_vol_ok: assert property (p_vol_ok) else $error("volatile pot permit");
	a_wp_nv: assert property (p_wp_nv) else $error("nv pot permit under wp");
	a_wp_keeps: assert property (p_wp_keeps) else $error("nv bits changed under wp");
	a_busy_unlock: assert property (p_busy_unlock) else $error("store start wrong");
	a_busy_len: assert property (p_busy_len) else $error("store too long");
endmodule : csr_chk

bind control_status_write_guard csr_chk #(.NV_STORE_CYCLES(NV_STORE_CYCLES)) chk (
	.clock(clock),
	.reset_n(reset_n),
	.write_protect(write_protect),
	.supply_ok(supply_ok),
	.mon2_reset_out(mon2_reset_out),
	.supply_reset_out(supply_reset_out),
	.pot_volatile_write_ok(pot_volatile_write_ok),
	.pot_nv_write_ok(pot_nv_write_ok),
	.nv_store_busy(nv_store_busy),
	.control_status_register(control_status_register)
);

`default_nettype wire
